/* itru_pkg.sv */
// Shared constants and carriers of the interrupt and test request unit
package itru_pkg;
    localparam int NSRC = 12;
    localparam int NTEST = 2;

    localparam logic [7:0] OFS_REQ   = 8'h00;
    localparam logic [7:0] OFS_MASK  = 8'h04;
    localparam logic [7:0] OFS_LEVEL = 8'h08;
    localparam logic [7:0] OFS_CTRL  = 8'h0c;
    localparam logic [7:0] OFS_TFLAG = 8'h10;
    localparam logic [7:0] OFS_TMASK = 8'h14;
    localparam logic [7:0] OFS_STAT  = 8'h18;

    localparam int CTRL_ME   = 0;
    localparam int CTRL_WDIV = 1;
    localparam int CTRL_ISP  = 2;
    localparam int STAT_NMI  = 0;
    localparam int STAT_TRAP = 1;
    localparam int TST_PORT4 = 0;
    localparam int TST_WATCH = 1;

    localparam logic [NSRC-1:0]  RST_MASK  = 12'hfff;
    localparam logic [NSRC-1:0]  RST_LEVEL = 12'hfff;
    localparam logic [NTEST-1:0] RST_TMASK = 2'h3;

    localparam logic [15:0] VEC_NMI  = 16'h0004;
    localparam logic [15:0] VEC_BASE = 16'h0004;
    localparam logic [15:0] VEC_TRAP = 16'h003e;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } itru_bus_t;

    typedef struct packed {
        logic        req;
        logic [15:0] addr;
    } itru_vec_t;

    typedef enum logic [1:0] {GR_NONE, GR_NMI, GR_TRAP, GR_MASK} itru_grant_t;
endpackage : itru_pkg

/* itru_core.sv */
// Interrupt and test request unit: flags, ranking, vectors and test inputs
// Notes on behaviour
// R1: Fourteen sources: one NMI, twelve maskable, trap.
// R2: Watchdog overflow in watchdog mode: NMI, 0004H.
// R3: Watchdog overflow in interval mode: maskable, priority 0.
// R4: Pending maskables ranked, level 0 first, 11 last.
// R5: Four pin edges: priorities 1-4, vectors 0006H-000CH.
// R6: Serial channel 0/1 transfer end: priorities 5, 6.
// R7: Watch tick, three timer matches: priorities 7-10.
// R8: Conversion end priority 11; vectors 000EH-001AH.
// R9: Software trap unmaskable, vectors to 003EH.
// R10: Per-source flag, mask, level; enable, in-service.
// R11: Watch overflow, port 4 fall set masked flags.
// R12: Acceptance clears flag, gives vector; NMI first.
// R13: Test flags only latch and wake, never vector.
//
// The plain strobed port and the register offsets were decided locally.
module itru_core (
    input  logic                clk_sys,
    input  logic                rst_b,
    input  logic                ce,
    input  itru_pkg::itru_bus_t bus,
    output logic [31:0]         rdata,
    input  logic                wdtOverflow,
    input  logic [3:0]          extPin,
    input  logic                serial0DoneReq,
    input  logic                serial1DoneReq,
    input  logic                watchTickReq,
    input  logic                wideTimerMatchReq,
    input  logic                byteTimer1MatchReq,
    input  logic                byteTimer2MatchReq,
    input  logic                adcDoneReq,
    input  logic [7:0]          port4Pin,
    input  logic                watchOverflow,
    input  logic                softTrap,
    input  logic                intAck,
    input  logic                retiDone,
    output itru_pkg::itru_vec_t vecOut,
    output logic                irq
);
    localparam int N = itru_pkg::NSRC;
    localparam int T = itru_pkg::NTEST;

    logic [N-1:0]          reqFlag;
    logic [N-1:0]          intMask;
    logic [N-1:0]          levelSel;
    logic                  masterEnable;
    logic                  wdtInterval;
    logic                  inService;
    logic                  nmiFlag;
    logic                  trapFlag;
    logic [T-1:0]          testFlag;
    logic [T-1:0]          testMask;
    logic [11:0]           pinS1;
    logic [11:0]           pinS2;
    logic [11:0]           pinS3;
    logic [11:0]           pinLvl;
    logic [11:0]           pinFall;
    logic [3:0]            extEdgeReq;
    logic                  port4Fall;
    logic                  watchdogOverflowReq;
    logic [N-1:0]          evt;
    logic [N-1:0]          elig;
    logic [N-1:0]          hiElig;
    logic [N-1:0]          busClr;
    logic [N-1:0]          ackClr;
    logic [N-1:0]          next_reqFlag;
    logic [T-1:0]          next_testFlag;
    itru_pkg::itru_grant_t grant;
    itru_pkg::itru_grant_t next_grant;
    logic [3:0]            grantIdx;
    logic [3:0]            next_grantIdx;
    logic [15:0]           next_addr;
    logic                  accepted;
    logic                  ackMask;

    function automatic logic [3:0] firstIdx(input logic [N-1:0] v);
        firstIdx = 4'h0;
        for (int i = N - 1; i >= 0; i--) begin
            if (v[i]) begin
                firstIdx = 4'(i);
            end
        end
    endfunction : firstIdx

    function automatic logic wrHit(input logic [7:0] ofs);
        wrHit = bus.wr && (bus.addr == ofs);
    endfunction : wrHit

    // Three stages; only the second and third are compared
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pinS1  <= 12'hfff;
            pinS2  <= 12'hfff;
            pinS3  <= 12'hfff;
            pinLvl <= 12'hfff;
        end else if (ce) begin
            pinS1  <= {port4Pin, extPin};
            pinS2  <= pinS1;
            pinS3  <= pinS2;
            pinLvl <= (pinLvl & (pinS2 ^ pinS3)) | (pinS3 & ~(pinS2 ^ pinS3));
        end
    end

    assign pinFall = pinLvl & ~pinS3 & ~(pinS2 ^ pinS3);
    assign extEdgeReq = pinFall[3:0]; // R5
    assign port4Fall = |pinFall[11:4]; // R11

    assign watchdogOverflowReq = wdtOverflow && wdtInterval; // R3
    // Index is the default priority; idx 0 is the highest
    assign evt = {adcDoneReq, byteTimer2MatchReq, byteTimer1MatchReq, // R8
                  wideTimerMatchReq, watchTickReq,                    // R7
                  serial1DoneReq, serial0DoneReq,                     // R6
                  extEdgeReq, watchdogOverflowReq};                   // R1

    // High level blocks all maskables while it is in service
    assign elig   = (masterEnable && !inService) ? (reqFlag & ~intMask) : '0; // R10
    assign hiElig = elig & ~levelSel; // R10

    always_comb begin
        next_grant    = itru_pkg::GR_NONE;
        next_grantIdx = 4'h0;
        next_addr     = 16'h0000;
        if (nmiFlag) begin
            next_grant = itru_pkg::GR_NMI; // R12
            next_addr  = itru_pkg::VEC_NMI; // R2
        end else if (trapFlag) begin
            next_grant = itru_pkg::GR_TRAP; // R9
            next_addr  = itru_pkg::VEC_TRAP; // R9
        end else if (elig != '0) begin
            next_grant    = itru_pkg::GR_MASK;
            next_grantIdx = (hiElig != '0) ? firstIdx(hiElig) : firstIdx(elig); // R4
            next_addr     = itru_pkg::VEC_BASE + {11'h000, next_grantIdx, 1'b0}; // R5 R8
        end
    end

    assign accepted = intAck && vecOut.req;
    assign ackMask  = accepted && (grant == itru_pkg::GR_MASK);
    assign ackClr   = ackMask ? ({{(N - 1){1'b0}}, 1'b1} << grantIdx) : '0;
    assign busClr   = wrHit(itru_pkg::OFS_REQ) ? bus.wdata[N-1:0] : '0;
    assign next_reqFlag = (reqFlag & ~(busClr | ackClr)) | evt; // R12

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reqFlag <= '0;
        end else if (ce) begin
            reqFlag <= next_reqFlag;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            nmiFlag  <= 1'b0;
            trapFlag <= 1'b0;
        end else if (ce) begin
            nmiFlag  <= (nmiFlag && !(accepted && grant == itru_pkg::GR_NMI))
                        || (wdtOverflow && !wdtInterval); // R2
            trapFlag <= (trapFlag && !(accepted && grant == itru_pkg::GR_TRAP))
                        || softTrap; // R9
        end
    end

    // Request drops one cycle after acceptance so a stale vector is never reused
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            vecOut   <= '0;
            grant    <= itru_pkg::GR_NONE;
            grantIdx <= 4'h0;
        end else if (ce) begin
            vecOut.req  <= !accepted && (next_grant != itru_pkg::GR_NONE); // R12
            vecOut.addr <= next_addr;
            grant       <= next_grant;
            grantIdx    <= next_grantIdx;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            intMask  <= itru_pkg::RST_MASK;
            levelSel <= itru_pkg::RST_LEVEL;
            testMask <= itru_pkg::RST_TMASK;
        end else if (ce) begin
            if (wrHit(itru_pkg::OFS_MASK)) begin
                intMask <= bus.wdata[N-1:0]; // R10
            end
            if (wrHit(itru_pkg::OFS_LEVEL)) begin
                levelSel <= bus.wdata[N-1:0]; // R10
            end
            if (wrHit(itru_pkg::OFS_TMASK)) begin
                testMask <= bus.wdata[T-1:0]; // R11
            end
        end
    end

    // Maskable or NMI acceptance drops the enable; a same-cycle software write loses
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            masterEnable <= 1'b0;
            wdtInterval  <= 1'b0;
        end else if (ce) begin
            if (wrHit(itru_pkg::OFS_CTRL)) begin
                wdtInterval  <= bus.wdata[itru_pkg::CTRL_WDIV];
                masterEnable <= bus.wdata[itru_pkg::CTRL_ME];
            end
            if (ackMask || (accepted && grant == itru_pkg::GR_NMI)) begin
                masterEnable <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            inService <= 1'b0;
        end else if (ce) begin
            if (ackMask && !levelSel[grantIdx]) begin
                inService <= 1'b1; // R10
            end else if (retiDone) begin
                inService <= 1'b0;
            end else if (wrHit(itru_pkg::OFS_CTRL)) begin
                inService <= bus.wdata[itru_pkg::CTRL_ISP];
            end
        end
    end

    // Test flags feed only the wake line
    always_comb begin
        next_testFlag = testFlag;
        if (wrHit(itru_pkg::OFS_TFLAG)) begin
            next_testFlag = testFlag & ~bus.wdata[T-1:0];
        end
        next_testFlag[itru_pkg::TST_PORT4] = next_testFlag[itru_pkg::TST_PORT4] | port4Fall;
        next_testFlag[itru_pkg::TST_WATCH] = next_testFlag[itru_pkg::TST_WATCH] | watchOverflow;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            testFlag <= '0;
            irq      <= 1'b0;
        end else if (ce) begin
            testFlag <= next_testFlag; // R11
            irq      <= |(next_testFlag & ~testMask); // R13
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= 32'h0000_0000;
        end else if (ce) begin
            rdata <= 32'h0000_0000;
            if (bus.rd) begin
                case (bus.addr)
                    itru_pkg::OFS_REQ:   rdata[N-1:0] <= reqFlag;
                    itru_pkg::OFS_MASK:  rdata[N-1:0] <= intMask;
                    itru_pkg::OFS_LEVEL: rdata[N-1:0] <= levelSel;
                    itru_pkg::OFS_CTRL:  rdata[2:0] <= {inService, wdtInterval, masterEnable};
                    itru_pkg::OFS_TFLAG: rdata[T-1:0] <= testFlag;
                    itru_pkg::OFS_TMASK: rdata[T-1:0] <= testMask;
                    itru_pkg::OFS_STAT:  rdata[1:0] <= {trapFlag, nmiFlag};
                    default:             rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    sequence maskAccept;
        ce && accepted && grant == itru_pkg::GR_MASK && !evt[grantIdx];
    endsequence

    sequence pin0Falls;
        (extPin[0] && ce)[*4] ##1 (!extPin[0] && ce && !intAck)[*6];
    endsequence

    nmi_vector_a: assert property (ce && nmiFlag && !accepted |=> // R2
        vecOut.req && vecOut.addr == itru_pkg::VEC_NMI)
        else $error("nmi not presented at its vector");
    // A pending nmi may remain; an interval overflow must not raise a new one
    wdt_interval_a: assert property (ce && wdtOverflow && wdtInterval |=> // R3
        reqFlag[0] && (!nmiFlag || $past(nmiFlag)))
        else $error("interval overflow not maskable");
    wdt_nmi_a: assert property (ce && wdtOverflow && !wdtInterval |=> nmiFlag) // R2
        else $error("watchdog overflow did not raise nmi");
    trap_vector_a: assert property (ce && trapFlag && !nmiFlag && !accepted |=> // R9
        vecOut.req && vecOut.addr == itru_pkg::VEC_TRAP)
        else $error("trap vector wrong");
    mask_vector_a: assert property (vecOut.req && grant == itru_pkg::GR_MASK |-> // R8
        vecOut.addr == itru_pkg::VEC_BASE + {11'h000, grantIdx, 1'b0})
        else $error("maskable vector wrong");
    top_priority_a: assert property (ce && !accepted && !nmiFlag && !trapFlag // R4
        && elig[0] && !levelSel[0] |=> grantIdx == 4'h0 && vecOut.addr == 16'h0004)
        else $error("priority 0 not chosen first");
    ack_clear_a: assert property (maskAccept |=> !reqFlag[$past(grantIdx)] // R12
        && !vecOut.req)
        else $error("accepted flag not cleared");
    ack_drop_a: assert property (ce && accepted |=> !vecOut.req) // R12
        else $error("request held after acceptance");
    ext_edge_a: assert property (pin0Falls |-> reqFlag[1]) // R5
        else $error("pin edge not flagged");
    port4_test_a: assert property (ce && port4Fall |=> testFlag[itru_pkg::TST_PORT4]) // R11
        else $error("port 4 test flag missed");
    test_novec_a: assert property (ce && !nmiFlag && !trapFlag && elig == '0 |=> // R13
        !vecOut.req)
        else $error("vector without a request");
endmodule : itru_core

/* itru_core_model.sv */
// Processor core model: takes presented vectors and returns from service
module itru_core_model (
    input  wire logic                clk_sys,
    input  wire logic                rst_b,
    input  wire itru_pkg::itru_vec_t vecOut,
    input  wire logic [3:0]          ackDelay,
    output logic                     intAck,
    output logic                     retiDone
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] waitCnt;
    logic       inIsr;

    // One service at a time, like a real core without nesting
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            intAck   <= 1'b0;
            retiDone <= 1'b0;
            waitCnt  <= 4'h0;
            inIsr    <= 1'b0;
        end else begin
            intAck   <= 1'b0;
            retiDone <= 1'b0;
            if (intAck) begin
                inIsr   <= 1'b1;
                waitCnt <= 4'h0;
            end else if (inIsr || vecOut.req) begin
                waitCnt <= waitCnt + 4'h1;
                if (waitCnt == ackDelay) begin
                    waitCnt  <= 4'h0;
                    inIsr    <= 1'b0;
                    retiDone <= inIsr;
                    intAck   <= !inIsr;
                end
            end
        end
    end
endmodule : itru_core_model

/* tb_top.sv */
// Self-checking testbench of the interrupt and test request unit
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic                clk_sys = 1'b0;
    logic                rst_b = 1'b0;
    itru_pkg::itru_bus_t bus = '0;
    logic [31:0]         rdata;
    logic                wdtOverflow = 1'b0;
    logic [3:0]          extPin = 4'hf;
    logic [6:0]          perReq = 7'h0;
    logic [7:0]          port4Pin = 8'hff;
    logic                watchOverflow = 1'b0;
    logic                softTrap = 1'b0;
    logic                intAck;
    logic                retiDone;
    itru_pkg::itru_vec_t vecOut;
    logic                irq;
    logic [3:0]          ackDelay = 4'h0;
    logic                rdPend = 1'b0;
    logic                ce = 1'b1;
    int                  seed = 32'hd3ea127a;
    int                  err_total = 0;
    int                  check_count = 0;
    logic [31:0]         expRd[$];
    logic [15:0]         expVec[$];
    logic [7:0]          rstAddr[8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};
    logic [31:0]         rstVal[8] = '{32'h0, 32'hfff, 32'hfff, 32'h0, 32'h0, 32'h3, 32'h0, 32'h0};

    always #20 clk_sys = ~clk_sys;

    itru_core u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .bus(bus), .rdata(rdata),
        .wdtOverflow(wdtOverflow), .extPin(extPin), .serial0DoneReq(perReq[0]),
        .serial1DoneReq(perReq[1]), .watchTickReq(perReq[2]), .wideTimerMatchReq(perReq[3]),
        .byteTimer1MatchReq(perReq[4]), .byteTimer2MatchReq(perReq[5]), .adcDoneReq(perReq[6]),
        .port4Pin(port4Pin), .watchOverflow(watchOverflow), .softTrap(softTrap),
        .intAck(intAck), .retiDone(retiDone), .vecOut(vecOut), .irq(irq));

    itru_core_model u_core (.clk_sys(clk_sys), .rst_b(rst_b), .vecOut(vecOut),
        .ackDelay(ackDelay), .intAck(intAck), .retiDone(retiDone));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict

    // Results watcher: read data the cycle after a read, vectors at acceptance
    always @(posedge clk_sys) begin
        if (rdPend) chk("read data", expRd.pop_front(), rdata);
        if (intAck && vecOut.req) begin
            if (expVec.size() == 0) chk("stray vector", 32'h0, 32'(vecOut.addr));
            else chk("vector", 32'(expVec.pop_front()), 32'(vecOut.addr));
        end
        rdPend <= bus.rd;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_sys);
        bus.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        expRd.push_back(e);
        @(posedge clk_sys);
        bus.rd <= 1'b0;
    endtask : rd

    // Misc bits: 0 watchdog overflow, 1 trap, 2 watch overflow and port 4 fall
    task automatic pulse(input logic [3:0] ext, input logic [6:0] per, input logic [2:0] misc);
        @(posedge clk_sys);
        extPin <= ~ext;
        perReq <= per;
        port4Pin <= {7'h7f, ~misc[2]};
        {watchOverflow, softTrap, wdtOverflow} <= misc;
        @(posedge clk_sys);
        perReq <= 7'h0;
        {watchOverflow, softTrap, wdtOverflow} <= 3'h0;
        // Pins stay low six cycles: the synchroniser filters one-cycle glitches
        repeat (5) @(posedge clk_sys);
        extPin <= 4'hf;
        port4Pin <= 8'hff;
        repeat (8) @(posedge clk_sys);
    endtask : pulse

    task automatic waitVec();
        int n;
        n = 0;
        while (expVec.size() != 0 && n < 400) begin
            @(posedge clk_sys);
            n++;
        end
        chk("vectors outstanding", 32'h0, 32'(expVec.size()));
    endtask : waitVec

    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        $display("mismatch watchdog expected done seen hang");
        print_verdict();
    end

    initial begin
        repeat (12) @(posedge clk_sys);
        rst_b <= 1'b1;
        for (int i = 0; i < 8; i++) rd(rstAddr[i], rstVal[i]);
        wr(8'h1c, $random(seed));
        rd(8'h1c, 32'h0);
        // Masked source only latches its flag
        pulse(4'h0, 7'h40, 3'h0);
        rd(itru_pkg::OFS_REQ, 32'h800);
        // All twelve maskables at once, one taken per enable
        ackDelay <= 4'($random(seed));
        wr(itru_pkg::OFS_MASK, 32'h0);
        wr(itru_pkg::OFS_CTRL, 32'h2);
        pulse(4'hf, 7'h7f, 3'h5);
        for (int i = 0; i < 12; i++) begin
            expVec.push_back(itru_pkg::VEC_BASE + 16'(2 * i));
            wr(itru_pkg::OFS_CTRL, 32'h3);
            waitVec();
        end
        rd(itru_pkg::OFS_REQ, 32'h0);
        // Test flags latch, gated by their masks onto irq only
        rd(itru_pkg::OFS_TFLAG, 32'h3);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(itru_pkg::OFS_TMASK, 32'h2);
        repeat (2) @(negedge clk_sys);
        chk("irq unmasked", 32'h1, {31'h0, irq});
        wr(itru_pkg::OFS_TFLAG, 32'h1);
        repeat (2) @(negedge clk_sys);
        chk("irq cleared", 32'h0, {31'h0, irq});
        rd(itru_pkg::OFS_TFLAG, 32'h2);
        // High level group wins and blocks the rest until return
        ackDelay <= 4'h8;
        wr(itru_pkg::OFS_LEVEL, 32'h7ff);
        pulse(4'h0, 7'h41, 3'h0);
        expVec.push_back(16'h001a);
        wr(itru_pkg::OFS_CTRL, 32'h3);
        waitVec();
        rd(itru_pkg::OFS_CTRL, 32'h6);
        expVec.push_back(16'h000e);
        wr(itru_pkg::OFS_CTRL, 32'h7);
        rd(itru_pkg::OFS_REQ, 32'h20);
        waitVec();
        // Watchdog mode overflow and trap ignore enable and masks
        wr(itru_pkg::OFS_CTRL, 32'h0);
        wr(itru_pkg::OFS_MASK, 32'hfff);
        expVec.push_back(16'h0004);
        expVec.push_back(16'h003e);
        pulse(4'h0, 7'h0, 3'h3);
        waitVec();
        rd(itru_pkg::OFS_STAT, 32'h0);
        // Clock enable low: a source pulse must leave no trace
        ce <= 1'b0;
        pulse(4'h0, 7'h01, 3'h0);
        ce <= 1'b1;
        rd(itru_pkg::OFS_REQ, 32'h0);
        print_verdict();
    end
endmodule : tb_top
